/* File: pmc_clock_loss.sv */
`timescale 1ns/1ns
`include "pmc_map.svh"
module pmc_clock_loss
  import pmc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `PMC_CLD_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic osc_stopped_i,
  output logic      reset_req_o
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        req_reg;
  logic        req_next;

  // Oscillator stop stands for lost clock; count models the timeout window
  always_comb begin
    count_next = count_reg;
    req_next   = 1'b0;
    if (!enable_i || !osc_stopped_i) begin
      count_next = 16'h0000;
    end else if (count_reg == 16'(TIMEOUT_CYCLES - 1)) begin
      req_next   = 1'b1;
      count_next = 16'h0000;
    end else begin
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= 16'h0000;
      req_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      req_reg   <= req_next;
    end
  end

  assign reset_req_o = req_reg;
endmodule

/* File: pmc_map.svh */
// What this block does
// - Light sleep halts CPU, clocks stay running
// - Deep sleep stops CPU, peripherals, oscillator
// - Light select bit sleeps after instruction ends
// - Light sleep keeps registers and memory intact
// - Light sleep ends on interrupt or reset
// - Interrupt wake clears light bit, services interrupt
// - Return resumes after the sleeping instruction
// - Reset wake restarts at address zero
// - Unserviced supervisory timer resets, ending light sleep
// - Deep select bit sleeps after instruction ends
// - Only reset ends deep sleep, restart zero
// - Clock loss detector reset ends deep sleep
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_PCTL_OFFSET   8'h87
`define PMC_PCTL_RESET    8'h00
`define PMC_LIGHT_BIT     0
`define PMC_DEEP_BIT      1
`define PMC_FLAGS_LSB     2
`define PMC_FLAGS_MSB     7
`define PMC_RESET_VECTOR  16'h0000
`define PMC_CLD_TIMEOUT_US 100
`define PMC_CLK_MHZ       250
`define PMC_CLD_CYCLES    (`PMC_CLD_TIMEOUT_US * `PMC_CLK_MHZ)
`endif

/* File: pmc_pkg.sv */
package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_RUN   = 3'b001,
    PMC_LIGHT = 3'b010,
    PMC_DEEP  = 3'b100
  } pmc_state_e;
  typedef struct packed {
    logic cpu_halt;
    logic periph_gate;
    logic osc_stop;
  } pmc_ctrl_s;
endpackage

/* File: pmc_power_control.sv */
`timescale 1ns/1ns
`include "pmc_map.svh"
module pmc_power_control
  import pmc_pkg::*;
#(
  parameter int unsigned CLD_TIMEOUT_CYCLES = `PMC_CLD_CYCLES
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       instr_done_i,
  input  wire logic       irq_pending_i,
  input  wire logic       ext_reset_i,
  input  wire logic       sup_timer_reset_i,
  input  wire logic       clock_loss_en_i,
  output logic            cpu_halt_o,
  output logic            periph_gate_o,
  output logic            osc_stop_o,
  output logic            wake_irq_o,
  output logic            sys_reset_o,
  output logic     [15:0] reset_vector_o
);
  pmc_state_e state_reg;
  pmc_state_e state_next;
  logic [7:0] pctl_reg;
  logic [7:0] pctl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       wake_reg;
  logic       wake_next;
  logic       rst_req_reg;
  logic       rst_req_next;
  logic       cld_req;
  pmc_ctrl_s  ctrl;

  pmc_clock_loss #(
    .TIMEOUT_CYCLES(CLD_TIMEOUT_CYCLES)
  ) u_cld (
    .core_clk_i   (core_clk_i),
    .rst_i        (rst_i),
    .enable_i     (clock_loss_en_i),
    .osc_stopped_i(state_reg == PMC_DEEP),
    .reset_req_o  (cld_req)
  );

  logic any_reset;
  logic irq_wake;
  assign any_reset = ext_reset_i | sup_timer_reset_i | cld_req;
  assign irq_wake  = !any_reset && (state_reg == PMC_LIGHT) && irq_pending_i;

  // Address decode is shared by the write and the read path
  function automatic logic pctl_hit(input logic [7:0] addr);
    return addr == `PMC_PCTL_OFFSET;
  endfunction

  // Software view of the register: the deep select never reads back
  function automatic logic [7:0] pctl_view(input logic [7:0] value);
    logic [7:0] view;
    view = value;
    view[`PMC_DEEP_BIT] = 1'b0;
    return view;
  endfunction

  // Sleep state group
  always_comb begin
    state_next = state_reg;
    if (any_reset) begin
      // Reset restarts the core at the vector
      state_next = PMC_RUN;
    end else begin
      unique case (state_reg)
        PMC_RUN: begin
          // Entry waits for the writing instruction to retire
          if (instr_done_i && pctl_reg[`PMC_DEEP_BIT]) begin
            state_next = PMC_DEEP;
          end else if (instr_done_i && pctl_reg[`PMC_LIGHT_BIT]) begin
            state_next = PMC_LIGHT;
          end
        end
        PMC_LIGHT: begin
          if (irq_pending_i) begin
            state_next = PMC_RUN;
          end
        end
        PMC_DEEP: begin
          state_next = PMC_DEEP;
        end
        default: begin
          state_next = PMC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= PMC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Register group; writes while asleep are dropped since no code runs then
  always_comb begin
    pctl_next = pctl_reg;
    if (any_reset) begin
      pctl_next = `PMC_PCTL_RESET;
    end else if (wr_i && pctl_hit(addr_i) && state_reg == PMC_RUN) begin
      pctl_next = wdata_i;
    end else if (irq_wake) begin
      pctl_next[`PMC_LIGHT_BIT] = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pctl_reg <= `PMC_PCTL_RESET;
    end else begin
      pctl_reg <= pctl_next;
    end
  end

  // Read group; data stands for one cycle only
  always_comb begin
    rdata_next = 8'h00;
    if (rd_i && pctl_hit(addr_i)) begin
      rdata_next = pctl_view(pctl_reg);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Event group: wake pulse and reset request
  always_comb begin
    wake_next    = irq_wake;
    rst_req_next = any_reset;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_reg    <= 1'b0;
      rst_req_reg <= 1'b0;
    end else begin
      wake_reg    <= wake_next;
      rst_req_reg <= rst_req_next;
    end
  end

  // Halt only gates fetch; no state is cleared, so contents are retained
  always_comb begin
    ctrl.cpu_halt    = (state_reg != PMC_RUN);
    ctrl.periph_gate = (state_reg == PMC_DEEP);
    ctrl.osc_stop    = (state_reg == PMC_DEEP);
  end

  assign cpu_halt_o     = ctrl.cpu_halt;
  assign periph_gate_o  = ctrl.periph_gate;
  assign osc_stop_o     = ctrl.osc_stop;
  assign rdata_o        = rdata_reg;
  assign wake_irq_o     = wake_reg;
  assign sys_reset_o    = rst_req_reg;
  assign reset_vector_o = `PMC_RESET_VECTOR;
endmodule

/* File: pmc_power_control_properties.sv */
`timescale 1ns/1ns
module pmc_power_control_properties (
  input wire logic core_clk_i, rst_i, wr_i, rd_i, instr_done_i, irq_pending_i,
  input wire logic ext_reset_i, sup_timer_reset_i, clock_loss_en_i, cpu_halt_o,
  input wire logic periph_gate_o, osc_stop_o, wake_irq_o, sys_reset_o,
  input wire logic [7:0] addr_i, wdata_i, rdata_o
);
  wire rs = ext_reset_i | sup_timer_reset_i;
  wire go = wr_i && addr_i == 8'h87 && !cpu_halt_o;
  wire en = instr_done_i && !rs && !irq_pending_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_lt; go && wdata_i[1:0] == 2'h1 ##1 en |=> cpu_halt_o && !osc_stop_o; endproperty
  a_lt: assert property (p_lt) else $error("light entry");
  property p_dp; go && wdata_i[1] ##1 en |=> osc_stop_o && periph_gate_o && cpu_halt_o; endproperty
  a_dp: assert property (p_dp) else $error("deep entry");
  property p_wk; cpu_halt_o && !osc_stop_o && irq_pending_i && !rs |=> wake_irq_o; endproperty
  a_wk: assert property (p_wk) else $error("irq wake");
  property p_dh; osc_stop_o && !rs && !clock_loss_en_i |=> osc_stop_o; endproperty
  a_dh: assert property (p_dh) else $error("deep left");
  property p_rs; rs |=> sys_reset_o && !cpu_halt_o; endproperty
  a_rs: assert property (p_rs) else $error("reset wake");
  property p_rd; rd_i |=> !rdata_o[1]; endproperty
  a_rd: assert property (p_rd) else $error("deep bit read");
  property p_ls; cpu_halt_o && !osc_stop_o |-> !periph_gate_o; endproperty
  a_ls: assert property (p_ls) else $error("light gate");
  property p_wp; wake_irq_o |-> $past(irq_pending_i) && !cpu_halt_o; endproperty
  a_wp: assert property (p_wp) else $error("wake cause");
endmodule
bind pmc_power_control pmc_power_control_properties u_pmc_power_control_properties (.*);

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic core_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, instr_done_i = 0, irq_pending_i = 0;
  logic ext_reset_i = 0, sup_timer_reset_i = 0, clock_loss_en_i = 0, cpu_halt_o;
  logic periph_gate_o, osc_stop_o, wake_irq_o, sys_reset_o;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [15:0] reset_vector_o;
  int n_fail = 0, n_tests = 0, cyc = 0;
  always #2 core_clk_i = ~core_clk_i;
  pmc_power_control #(.CLD_TIMEOUT_CYCLES(20)) u_pmc_power_control (.*);
  task end_sim;
    $display("%0d checks, %0d bad", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cmp(input logic [15:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // Reads reuse d as the expected data
  task acc(input logic w, input logic [7:0] a, d);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    {wr_i, rd_i} <= 2'h0;
    #1;
    if (!w) cmp(rdata_o, d);
  endtask
  task ev(input logic [3:0] v, input int n, input logic [2:0] e);
    {instr_done_i, irq_pending_i, ext_reset_i, sup_timer_reset_i} <= v;
    repeat (n) @(posedge core_clk_i);
    {instr_done_i, irq_pending_i, ext_reset_i, sup_timer_reset_i} <= 4'h0;
    #1;
    cmp({cpu_halt_o, periph_gate_o, osc_stop_o}, e);
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc > 1000) begin
      n_fail++;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 0;
    @(posedge core_clk_i);
    acc(1, 8'h87, 8'hFE);
    acc(0, 8'h87, 8'hFC);
    acc(1, 8'h86, 8'hFF);
    acc(0, 8'h86, 8'h00);
    acc(1, 8'h87, 8'hA5);
    ev(4'h8, 1, 3'h4);
    acc(1, 8'h87, 8'h00);
    acc(0, 8'h87, 8'hA5);
    ev(4'h4, 1, 3'h0);
    cmp(wake_irq_o, 1);
    acc(0, 8'h87, 8'hA4);
    acc(1, 8'h87, 8'h01);
    ev(4'h8, 1, 3'h4);
    ev(4'h1, 1, 3'h0);
    cmp({sys_reset_o, reset_vector_o[14:0]}, 16'h8000);
    $display("light sleep done");
    acc(1, 8'h87, 8'h03);
    ev(4'h8, 1, 3'h7);
    ev(4'h4, 5, 3'h7);
    ev(4'h2, 1, 3'h0);
    clock_loss_en_i <= 1;
    acc(1, 8'h87, 8'h02);
    ev(4'h8, 1, 3'h7);
    repeat (40) if (cpu_halt_o) #4;
    cmp(osc_stop_o, 0);
    $display("deep sleep done");
    end_sim;
  end
endmodule
